// File: core/wdt_defs.svh
// Register map, field positions, reset values and timing of the watchdog control
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH
`define CTL_OFS 2'h0
`define CNT_OFS 2'h1
`define FLAG_BIT 7
`define IE_BIT 6
`define P3_BIT 5
`define UNLOCK_BIT 4
`define RSTEN_BIT 3
`define PLO_MSB 2
`define CTL_RESET 8'h00
`define UNLOCK_CYCLES 3'h4
`define CLK_HZ 10000000
`define OSC_HZ 128000
`define TICK_DIV (`CLK_HZ / `OSC_HZ)
`define BASE_COUNT 2048
`define MAX_CODE 4'h9
`define TIMEOUT_VEC 5'h07
`define TIMEOUT_ADDR 12'h006
`define RESET_ADDR 12'h000
`endif

// File: core/wdt_pkg.sv
// Types shared by the watchdog control block
package wdt_pkg;
  typedef enum logic [1:0] {
    MODE_STOP = 2'b00,
    MODE_IRQ  = 2'b01,
    MODE_RST  = 2'b10,
    MODE_BOTH = 2'b11
  } mode_t;

  typedef struct packed {
    logic [3:0]  adr;
    logic [31:0] dat;
    logic [3:0]  sel;
    logic        we;
    logic        cyc;
    logic        stb;
  } wb_req_t;

  typedef struct packed {
    logic [4:0]  num;
    logic [11:0] addr;
  } vec_t;
endpackage : wdt_pkg

// File: core/wdt_ctrl.sv
// Watchdog timer with mode control, timed unlock and Wishbone register access
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defs.svh"

module wdt_ctrl #(
  parameter int TICK_DIV   = `TICK_DIV,
  parameter int BASE_COUNT = `BASE_COUNT,
  parameter int CNT_W      = 21
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Wishbone slave
  input  wire wdt_pkg::wb_req_t wb_i,
  output logic [31:0]           dat_o,
  output logic                  ack_o,
  // Processor side
  input  wire logic             restart_i,
  input  wire logic             gie_i,
  input  wire logic             irq_ack_i,
  input  wire logic             reset_cause_flag_i,
  input  wire logic             always_on_fuse_i,
  // Watchdog actions
  output logic                  irq_o,
  output wdt_pkg::vec_t         irq_vec_o,
  output logic                  sys_reset_o,
  output wdt_pkg::vec_t         reset_vec_o,
  output wdt_pkg::mode_t        mode_o
);
  import wdt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Period decode

  function automatic logic [CNT_W-1:0] period_last(input logic [3:0] code);
    logic [3:0] c;
    c = (code > `MAX_CODE) ? `MAX_CODE : code;
    period_last = (CNT_W'(BASE_COUNT) << c) - CNT_W'(1);
  endfunction : period_last

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic             ack_r;
  logic [31:0]      dat_r;
  logic             flag_r;
  logic             ie_r;
  logic             rsten_r;
  logic             unlock_r;
  logic [2:0]       unlock_cnt_r;
  logic [3:0]       period_r;
  logic [7:0]       div_r;
  logic [CNT_W-1:0] cnt_r;
  logic             rst_pulse_r;

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  wire        req      = wb_i.cyc & wb_i.stb;
  wire        take     = req & ~ack_r;
  wire        sel_ctl  = wb_i.adr[3:2] == `CTL_OFS;
  wire        sel_cnt  = wb_i.adr[3:2] == `CNT_OFS;
  wire        wr_ctl   = req & ack_r & wb_i.we & sel_ctl & wb_i.sel[0];
  wire [7:0]  wd       = wb_i.dat[7:0];
  wire        wr_ie    = wd[`IE_BIT];
  wire        wr_rsten = wd[`RSTEN_BIT];
  wire        wr_unl   = wd[`UNLOCK_BIT];
  wire        wr_flag  = wd[`FLAG_BIT];
  wire [3:0]  wr_per   = {wd[`P3_BIT], wd[`PLO_MSB:0]};

  wire        rsten_eff = rsten_r | reset_cause_flag_i | always_on_fuse_i;
  wire        ie_eff    = ie_r & ~always_on_fuse_i;
  wire [CNT_W-1:0] last = period_last(period_r);
  wire        tick      = div_r == 8'(TICK_DIV - 1);

  mode_t mode;
  assign mode = always_on_fuse_i ? MODE_RST : mode_t'({rsten_eff, ie_eff});

  wire [7:0] ctl_rd = {flag_r, ie_eff, period_r[3], unlock_r,
                       rsten_eff, period_r[2:0]};
  wire [31:0] rd_val = sel_ctl ? {24'h0, ctl_rd} :
                       sel_cnt ? 32'(cnt_r) : 32'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Mode actions

  logic run;
  logic set_flag;
  logic do_reset;
  wire  at_last = tick & (cnt_r == last);
  wire  timeout = run & at_last;

  always_comb begin
    run      = 1'b1;
    set_flag = 1'b0;
    do_reset = 1'b0;
    case (mode)
      MODE_STOP: begin
        run = 1'b0;
      end
      MODE_IRQ: begin
        set_flag = timeout;
      end
      MODE_RST: begin
        do_reset = timeout;
      end
      MODE_BOTH: begin
        if (flag_r && !irq_ack_i) begin
          do_reset = timeout;
        end else begin
          set_flag = timeout;
        end
      end
      default: begin
        run = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next values of control bits

  logic       rsten_nxt;
  logic       ie_nxt;
  logic       flag_nxt;
  logic [3:0] period_nxt;

  always_comb begin
    rsten_nxt  = rsten_r;
    period_nxt = period_r;
    ie_nxt     = ie_r;
    if (irq_ack_i && mode == MODE_BOTH) begin
      ie_nxt = 1'b0;
    end
    if (wr_ctl) begin
      ie_nxt = wr_ie;
      if (wr_rsten) begin
        rsten_nxt = 1'b1;
      end else if (unlock_r && !reset_cause_flag_i) begin
        rsten_nxt = 1'b0;
      end
      if (unlock_r) begin
        period_nxt = wr_per;
      end
    end
    flag_nxt = flag_r;
    if (irq_ack_i || (wr_ctl && wr_flag)) begin
      flag_nxt = 1'b0;
    end
    if (set_flag) begin
      flag_nxt = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_r   <= 1'b0;
      ie_r     <= 1'b0;
      rsten_r  <= 1'b0;
      period_r <= 4'h0;
    end else begin
      flag_r   <= flag_nxt;
      ie_r     <= ie_nxt;
      rsten_r  <= rsten_nxt;
      period_r <= period_nxt;
    end
  end

  // Unlock window, open for a fixed number of clocks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unlock_r     <= 1'b0;
      unlock_cnt_r <= 3'h0;
    end else if (unlock_r) begin
      unlock_cnt_r <= unlock_cnt_r + 3'h1;
      if (unlock_cnt_r == `UNLOCK_CYCLES - 3'h1) begin
        unlock_r <= 1'b0;
      end
    end else if (wr_ctl && wr_unl) begin
      unlock_r     <= 1'b1;
      unlock_cnt_r <= 3'h0;
    end
  end

  // Watchdog oscillator rate enable
  always_ff @(posedge clk_i) begin
    if (rst_i || tick) begin
      div_r <= 8'h00;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  // Time-out counter
  always_ff @(posedge clk_i) begin
    if (rst_i || restart_i || !run) begin
      cnt_r <= '0;
    end else if (at_last) begin
      cnt_r <= '0;
    end else if (tick) begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_pulse_r <= 1'b0;
    end else begin
      rst_pulse_r <= do_reset;
    end
  end

  // Bus answer one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
    end else begin
      ack_r <= take;
      if (take) begin
        dat_r <= rd_val;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign ack_o            = ack_r;
  assign dat_o            = dat_r;
  assign irq_o            = flag_r & ie_eff & gie_i;
  assign irq_vec_o.num    = `TIMEOUT_VEC;
  assign irq_vec_o.addr   = `TIMEOUT_ADDR;
  assign sys_reset_o      = rst_pulse_r;
  assign reset_vec_o.num  = 5'h01;
  assign reset_vec_o.addr = `RESET_ADDR;
  assign mode_o           = mode;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  unlock_close_a: assert property (
    $rose(unlock_r) |-> unlock_r [*4] ##1 !unlock_r)
    else $error("unlock window not four cycles");

  cause_read_a: assert property (
    reset_cause_flag_i |-> ctl_rd[`RSTEN_BIT])
    else $error("reset enable reads clear under cause flag");

  fuse_lock_a: assert property (
    always_on_fuse_i |-> mode == MODE_RST && !ie_eff && rsten_eff)
    else $error("fuse does not force reset mode");

  irq_mode_a: assert property (
    mode == MODE_IRQ && timeout |=> flag_r && !sys_reset_o)
    else $error("interrupt mode time-out missed");

  irq_gate_a: assert property (
    irq_o |-> gie_i && ie_eff && flag_r)
    else $error("interrupt raised while not allowed");

  both_first_a: assert property (
    mode == MODE_BOTH && timeout && !flag_r |=> flag_r && !sys_reset_o)
    else $error("combined first time-out wrong");

  both_second_a: assert property (
    mode == MODE_BOTH && timeout && flag_r && !irq_ack_i |=> sys_reset_o)
    else $error("unserviced time-out did not reset");

  vector_clear_a: assert property (
    mode == MODE_BOTH && irq_ack_i && !wr_ctl && !timeout |=> !ie_r && !flag_r)
    else $error("vector did not clear enable and flag");

  reset_mode_a: assert property (
    mode == MODE_RST && timeout |=> sys_reset_o ##1 !sys_reset_o)
    else $error("reset mode time-out wrong");

  stop_hold_a: assert property (
    mode == MODE_STOP |=> cnt_r == '0 && !sys_reset_o)
    else $error("stopped watchdog counting");

  locked_period_a: assert property (
    !unlock_r |=> $stable(period_r))
    else $error("period changed without unlock");

  restart_zero_a: assert property (
    restart_i |=> cnt_r == '0)
    else $error("restart did not clear counter");

  period_cap_a: assert property (
    period_r > `MAX_CODE |-> last == period_last(`MAX_CODE))
    else $error("reserved code not longest period");

  bus_ack_a: assert property (
    take |=> ack_o ##1 !ack_o)
    else $error("bus answer timing wrong");

  // Flag, enable and period guards
  flag_w1c_a: assert property (
    wr_ctl && wr_flag && !set_flag |=> !flag_r)
    else $error("flag not cleared by writing one");

  set_wins_a: assert property (
    set_flag |=> flag_r)
    else $error("time-out flag lost against a clear");

  rsten_locked_a: assert property (
    rsten_r && !unlock_r |=> rsten_r)
    else $error("reset enable cleared without unlock");

  cause_keep_a: assert property (
    rsten_r && reset_cause_flag_i |=> rsten_r)
    else $error("reset enable cleared under cause flag");

  period_load_a: assert property (
    wr_ctl && unlock_r |=> period_r == $past(wr_per))
    else $error("unlocked period write lost");

  // Counter only moves on a rate tick, a restart or a stop
  count_hold_a: assert property (
    run && !restart_i && !tick |=> $stable(cnt_r))
    else $error("counter moved between rate ticks");

  read_ctl_a: assert property (
    take && !wb_i.we && sel_ctl |=> dat_o == {24'h0, $past(ctl_rd)})
    else $error("control read data wrong");

  cover_irq_c: cover property (mode == MODE_IRQ && timeout ##1 irq_o);
  cover_both_c: cover property (mode == MODE_BOTH && timeout ##[1:8] irq_ack_i);
  cover_reset_c: cover property (sys_reset_o);
  cover_unlock_c: cover property ($rose(unlock_r) ##[1:3] wr_ctl && !wr_rsten);
  cover_restart_c: cover property (restart_i ##1 cnt_r == '0 ##[1:8] tick);

endmodule : wdt_ctrl
`default_nettype wire

// File: verif/watchdog_timer_mode_control_test.sv
// Self-checking bench for the watchdog control block
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer_mode_control_test;
  import wdt_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        restart_i = 1'b0;
  logic        gie_i = 1'b0;
  logic        irq_ack_i = 1'b0;
  logic        cause = 1'b0;
  logic        fuse = 1'b0;
  wb_req_t     wb_i = '0;
  logic [31:0] dat_o;
  logic [31:0] rd;
  logic        ack_o;
  logic        irq_o;
  logic        sys_reset_o;
  vec_t        irq_vec_o;
  vec_t        reset_vec_o;
  mode_t       mode_o;
  int          err_total = 0;
  int          n_tests = 0;
  int          rst_cnt = 0;
  int          n;
  int          c0;

  always #50 clk_i = ~clk_i;
  always @(negedge clk_i) begin
    if (sys_reset_o === 1'b1) rst_cnt++;
  end

  wdt_ctrl #(.TICK_DIV(2), .BASE_COUNT(4)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .dat_o(dat_o),
    .ack_o(ack_o), .restart_i(restart_i), .gie_i(gie_i), .irq_ack_i(irq_ack_i), .reset_cause_flag_i(cause),
    .always_on_fuse_i(fuse), .irq_o(irq_o), .irq_vec_o(irq_vec_o), .sys_reset_o(sys_reset_o),
    .reset_vec_o(reset_vec_o), .mode_o(mode_o));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Classic single cycle, held until ack is seen
  task automatic bus(input logic we, input logic [3:0] adr, input logic [7:0] wd);
    @(posedge clk_i);
    wb_i <= '{adr: adr, dat: {24'h000000, wd}, sel: 4'hF, we: we, cyc: 1'b1, stb: 1'b1};
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rd = dat_o;
    wb_i <= '0;
  endtask : bus

  task automatic wr(input logic [7:0] v);
    bus(1'b1, 4'h0, v);
  endtask : wr

  task automatic rdc();
    bus(1'b0, 4'h0, 8'h00);
  endtask : rdc

  // Unlock, then protected write
  task automatic set_ctl(input logic [7:0] v);
    wr(8'h18);
    wr(v);
  endtask : set_ctl

  task automatic kick(input logic ack);
    @(posedge clk_i);
    restart_i <= !ack;
    irq_ack_i <= ack;
    @(posedge clk_i);
    restart_i <= 1'b0;
    irq_ack_i <= 1'b0;
  endtask : kick

  task automatic poll_flag();
    int k;
    k = 0;
    do begin
      rdc();
      k++;
    end while (rd[7] !== 1'b1 && k < 100);
    chk("flag seen", 32'(rd[7]), 32'h1);
  endtask : poll_flag

  task automatic time_reset();
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    // Pulse at n=1 was launched before the restart took hold
    end while ((sys_reset_o !== 1'b1 || n < 2) && n < 5000);
  endtask : time_reset

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdc();
    chk("ctl reset", rd, 32'h0);
    chk("irq vec", 32'(irq_vec_o), 32'h07006);
    chk("rst vec", 32'(reset_vec_o), 32'h01000);
    chk("mode stop", 32'(mode_o), 32'(MODE_STOP));
    bus(1'b0, 4'h4, 8'h00);
    chk("count stopped", rd, 32'h0);
    bus(1'b0, 4'h8, 8'h00);
    chk("unmapped", rd, 32'h0);
    $display("done: reset");
  endtask : t_reset

  task automatic t_unlock();
    wr(8'h08);
    wr(8'h01);
    rdc();
    chk("locked", rd, 32'h08);
    wr(8'h18);
    repeat (5) @(posedge clk_i);
    rdc();
    chk("unlock expiry", rd, 32'h08);
    wr(8'h01);
    rdc();
    chk("closed", rd, 32'h08);
    set_ctl(8'h01);
    rdc();
    chk("opened", rd, 32'h01);
    $display("done: unlock");
  endtask : t_unlock

  task automatic t_period();
    logic [3:0] codes[6] = '{4'h0, 4'h1, 4'h5, 4'h8, 4'h9, 4'hB};
    logic [7:0] v;
    int         e;
    foreach (codes[i]) begin
      v = {2'b00, codes[i][3], 2'b01, codes[i][2:0]};
      set_ctl(v);
      rdc();
      chk("period field", rd, 32'(v));
      kick(1'b0);
      time_reset();
      e = 2 * (4 << ((codes[i] > 4'h9) ? 9 : int'(codes[i])));
      chk("period len", 32'(n >= e - 3 && n <= e + 3), 32'h1);
    end
    set_ctl(8'h00);
    c0 = rst_cnt;
    repeat (40) @(posedge clk_i);
    chk("stopped", 32'(rst_cnt - c0), 32'h0);
    $display("done: period");
  endtask : t_period

  task automatic t_irq();
    set_ctl(8'h43);
    c0 = rst_cnt;
    kick(1'b0);
    poll_flag();
    chk("irq mode", 32'(mode_o), 32'(MODE_IRQ));
    chk("irq gated", 32'(irq_o), 32'h0);
    @(posedge clk_i);
    gie_i <= 1'b1;
    @(negedge clk_i);
    chk("irq raised", 32'(irq_o), 32'h1);
    kick(1'b1);
    rdc();
    chk("vector clears", rd, 32'h43);
    poll_flag();
    wr(8'hC3);
    rdc();
    chk("w1c flag", rd, 32'h43);
    chk("no reset", 32'(rst_cnt - c0), 32'h0);
    $display("done: irq");
  endtask : t_irq

  task automatic t_both();
    set_ctl(8'h4B);
    c0 = rst_cnt;
    kick(1'b0);
    poll_flag();
    chk("first timeout", 32'(rst_cnt - c0), 32'h0);
    chk("both irq", 32'(irq_o), 32'h1);
    kick(1'b1);
    rdc();
    chk("to reset mode", rd, 32'h0B);
    chk("mode rst", 32'(mode_o), 32'(MODE_RST));
    kick(1'b0);
    wr(8'h4B);
    poll_flag();
    time_reset();
    chk("unserviced", 32'(n <= 70), 32'h1);
    $display("done: both");
  endtask : t_both

  task automatic t_lock();
    @(posedge clk_i);
    cause <= 1'b1;
    set_ctl(8'h00);
    rdc();
    chk("cause holds", rd & 32'h6F, 32'h08);
    cause <= 1'b0;
    set_ctl(8'h00);
    rdc();
    chk("cause freed", rd & 32'h6F, 32'h00);
    fuse <= 1'b1;
    wr(8'h40);
    rdc();
    chk("fuse bits", rd & 32'h6F, 32'h08);
    chk("fuse mode", 32'(mode_o), 32'(MODE_RST));
    $display("done: lock");
  endtask : t_lock

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_unlock();
    t_period();
    t_irq();
    t_both();
    t_lock();
    print_verdict();
  end

  initial begin
    repeat (60000) @(posedge clk_i);
    err_total++;
    print_verdict();
  end
endmodule : watchdog_timer_mode_control_test
`default_nettype wire
